// ===== rtl/rfbi_blk_cfg.sv
// configuration, jumper capture and address decode of one rom/flash block
`include "rfbi_defines.svh"
module rfbi_blk_cfg
  import rfbi_pkg::*;
#(
  parameter logic [11:0] BASE_RST = `RFBI_BASE_A_RST
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_ce,
  input  wire logic                     i_cfg_we,
  input  wire rfbi_cfg_s                i_cfg,
  input  wire logic                     i_jmp_rve,
  input  wire logic                     i_jmp_wide,
  input  wire logic [31:0]              i_addr,
  output rfbi_stat_s                    o_stat,
  output logic                          o_rd_hit,
  output logic                          o_wr_hit,
  output logic [`RFBI_OFF_W-1:0]        o_off
);
  rfbi_cfg_s   cfg_r;
  logic        wide_r;
  logic        ready_r;
  logic [1:0]  strap_cnt_r;
  logic        strap_load;
  logic [11:0] mask;
  logic        base_hit;
  logic        alias_hit;
  logic [2:0]  size_wr;

  assign strap_load = !ready_r && (strap_cnt_r == `RFBI_STRAP_WAIT);
  assign size_wr    = (i_cfg.size > `RFBI_SIZE_MAX) ? `RFBI_SIZE_MAX : i_cfg.size;
  assign mask       = `RFBI_MASK_ALL << cfg_r.size;
  assign base_hit   = ((i_addr[31:20] ^ cfg_r.base) & mask) == 12'h000;
  // first megabyte also at the top
  assign alias_hit  = cfg_r.rve && (i_addr[31:20] == `RFBI_ALIAS_HI);
  // reads claimed only when enabled or aliased
  assign o_rd_hit   = ready_r && ((cfg_r.en && base_hit) || alias_hit);
  assign o_wr_hit   = o_rd_hit;
  assign o_off      = alias_hit ? {6'h00, i_addr[`RFBI_ALIAS_LSB-1:0]}
                    : {i_addr[25:20] & ~mask[5:0], i_addr[19:0]};
  assign o_stat     = '{cfg: cfg_r, wide: wide_r, ready: ready_r};

  // ****************************************
  // registers
  // ****************************************
  // enables cleared, straps caught after release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r       <= '{en: 1'b0, wen: 1'b0, rve: 1'b0, base: BASE_RST,
                       size: `RFBI_SIZE_RST, atime: 4'h0};
      wide_r      <= 1'b0;
      ready_r     <= 1'b0;
      strap_cnt_r <= 2'h0;
    end else if (i_ce) begin
      if (!ready_r) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
      if (strap_load) begin
        ready_r    <= 1'b1;
        cfg_r.rve  <= i_jmp_rve;
        wide_r     <= i_jmp_wide;
      end else if (i_cfg_we && ready_r) begin
        cfg_r      <= i_cfg;
        cfg_r.size <= size_wr;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_en_by_sw;
    @(posedge i_clk) disable iff (i_rst)
    $rose(cfg_r.en) |-> $past(i_cfg_we) && $past(ready_r);
  endproperty
  a_en_by_sw: assert property (p_en_by_sw) else $error("enable set without write");

  property p_wide_ro;
    @(posedge i_clk) disable iff (i_rst)
    $changed(wide_r) |-> $past(strap_load);
  endproperty
  a_wide_ro: assert property (p_wide_ro) else $error("width changed by software");

  property p_alias;
    @(posedge i_clk) disable iff (i_rst)
    (ready_r && cfg_r.rve && i_addr[31:20] == `RFBI_ALIAS_HI)
      |-> o_rd_hit && o_off[25:20] == 6'h00;
  endproperty
  a_alias: assert property (p_alias) else $error("alias not decoded");

  property p_base_rst;
    @(posedge i_clk) disable iff (i_rst)
    $changed(cfg_r.base) || $changed(cfg_r.size) |-> $past(i_cfg_we);
  endproperty
  a_base_rst: assert property (p_base_rst) else $error("base or size lost value");
endmodule

// ===== rtl/rfbi_defines.svh
// constants of the rom/flash block interface: offsets, reset values, timing
`ifndef RFBI_DEFINES_SVH
`define RFBI_DEFINES_SVH
// region base reset values, address bits 31:20
`define RFBI_BASE_A_RST  12'hFF0
`define RFBI_BASE_B_RST  12'hFF4
// reset-vector alias window, address bits 31:20
`define RFBI_ALIAS_HI    12'hFFF
// size code: region spans 1 MB shifted left by the code, 64 MB at most
`define RFBI_SIZE_RST    3'h0
`define RFBI_SIZE_MAX    3'h6
`define RFBI_MASK_ALL    12'hFFF
`define RFBI_ALIAS_LSB   20
`define RFBI_OFF_W       26
// cycles after reset release before the jumper synchronisers hold valid levels
`define RFBI_STRAP_WAIT  2'h2
// extra read cycles so device data has crossed the two pin flip-flops
`define RFBI_SYNC_LAT    5'h02
// byte counts per transfer size, then beats per 64-bit burst and the single-access count
`define RFBI_N_BYTE      6'h01
`define RFBI_N_HALF      6'h02
`define RFBI_N_WORD      6'h04
`define RFBI_N_DWORD     6'h08
`define RFBI_N_BURST     6'h20
`define RFBI_BURST_BEATS 6'h04
`define RFBI_ONE_ACC     6'h01
// offset step per device access
`define RFBI_STEP_WIDE   26'h0000008
`define RFBI_STEP_NARROW 26'h0000001
// data lanes: upper device on the upper half of the data bus
`define RFBI_UP_LSB      32
`define RFBI_LAST_LANE   3'h7
`define RFBI_WE_UPPER    2'h2
`define RFBI_WE_LOWER    2'h1
`define RFBI_WE_NONE     2'h0
`endif

// ===== rtl/rfbi_pkg.sv
// types of the rom/flash block interface
package rfbi_pkg;
  typedef enum logic [2:0] {
    SZ_BYTE,
    SZ_HALF,
    SZ_WORD,
    SZ_DWORD,
    SZ_BURST
  } rfbi_size_e;

  // software configuration of one block
  typedef struct packed {
    logic        en;
    logic        wen;
    logic        rve;
    logic [11:0] base;
    logic [2:0]  size;
    logic [3:0]  atime;
  } rfbi_cfg_s;

  // readable state of one block
  typedef struct packed {
    rfbi_cfg_s cfg;
    logic      wide;
    logic      ready;
  } rfbi_stat_s;

  // processor bus request
  typedef struct packed {
    logic [31:0] addr;
    logic        wr;
    rfbi_size_e  size;
    logic [31:0] wdata;
  } rfbi_req_s;
endpackage

// ===== rtl/rfbi_top.sv
// rom/flash block interface of the memory controller: two blocks behind the processor bus
// Behaviour
// - two rom/flash blocks, each with address and control for up to 64 MB in 64-bit mode, 16 MB in 16-bit mode.
// - per block, software sets overall enable, write enable and reset-vector enable.
// - with reset-vector enable set, first megabyte also decodes at FFF00000.
// - reset clears enable and write enable; reset-vector enable comes from a jumper.
// - base programmable; block A resets to FF000000, block B to FF400000.
// - size programmable, reset to the smallest setting.
// - access time programmable per block and times each device cycle.
// - width taken from a jumper at reset, readable, never written by software.
// - width bit clear means 16 bits, one 8-bit device per half.
// - in 16-bit mode only byte writes; other sizes silently ignored.
// - in 16-bit mode all reads, one device access per byte.
// - width bit set means 64 bits, 32 data bits per half.
// - in 64-bit mode only aligned word writes; others ignored.
// - in 64-bit mode all reads; bursts take several device accesses.
// - 16-bit address is group times four plus low bits; offset 0-3 upper.
// - 64-bit address is byte address over eight; bytes 0-3 upper device.
`include "rfbi_defines.svh"
module rfbi_top
  import rfbi_pkg::*;
(
  input  wire logic              I_MCLK,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  input  wire logic [1:0]        I_CFG_WE,
  input  wire rfbi_cfg_s         I_CFG,
  input  wire logic [1:0]        I_JMP_RVE,
  input  wire logic [1:0]        I_JMP_WIDE,
  input  wire logic              I_REQ,
  input  wire rfbi_req_s         I_REQ_D,
  input  wire logic [63:0]       I_ROM_DIN,
  output rfbi_stat_s [1:0]       O_STAT,
  output logic                   O_BUSY,
  output logic                   O_ACK,
  output logic                   O_RVALID,
  output logic [63:0]            O_RDATA,
  output logic [1:0]             O_ROM_CS,
  output logic [22:0]            O_ROM_ADDR,
  output logic                   O_ROM_OE,
  output logic [1:0]             O_ROM_WE,
  output logic [63:0]            O_ROM_DOUT,
  output logic                   O_ROM_DOE
);
  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_DONE} rfbi_state_e;

  rfbi_state_e            st_r;
  logic [3:0]             jmp_s1_r;
  logic [3:0]             jmp_s2_r;
  logic [63:0]            din_s1_r;
  logic [63:0]            din_s2_r;
  logic [1:0]             rd_hit;
  logic [1:0]             wr_hit;
  logic [`RFBI_OFF_W-1:0] blk_off [2];
  logic                   sel;
  logic                   any_hit;
  logic                   start;
  logic                   wide_sel;
  logic                   size_ok;
  logic                   wr_ok;
  logic                   skip;
  logic [5:0]             nbytes;
  logic [5:0]             n_acc;
  logic [4:0]             limit;
  logic                   acc_end;
  logic                   last;
  logic                   beat_end;
  logic                   go;
  logic [`RFBI_OFF_W-1:0] off_step;
  logic [`RFBI_OFF_W-1:0] off_nxt;
  logic [22:0]            addr_nxt;
  logic [7:0]             byte_in;
  logic [63:0]            buf_nxt;

  // access context
  logic [`RFBI_OFF_W-1:0] off_r;
  logic [5:0]             left_r;
  logic [4:0]             cnt_r;
  logic                   wr_r;
  logic                   wide_r;
  logic                   blk_r;
  logic [3:0]             atime_r;
  logic [63:0]            buf_r;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      jmp_s1_r <= 4'h0;
      jmp_s2_r <= 4'h0;
      din_s1_r <= 64'h0;
      din_s2_r <= 64'h0;
    end else if (I_CE) begin
      jmp_s1_r <= {I_JMP_WIDE, I_JMP_RVE};
      jmp_s2_r <= jmp_s1_r;
      din_s1_r <= I_ROM_DIN;
      din_s2_r <= din_s1_r;
    end
  end

  // ****************************************
  // blocks
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_blk
      rfbi_blk_cfg #(
        .BASE_RST   ((g == 0) ? `RFBI_BASE_A_RST : `RFBI_BASE_B_RST)
      ) rfbi_blk_cfg_inst (
        .i_clk      (I_MCLK),
        .i_rst      (I_RST),
        .i_ce       (I_CE),
        .i_cfg_we   (I_CFG_WE[g]),
        .i_cfg      (I_CFG),
        .i_jmp_rve  (jmp_s2_r[g]),
        .i_jmp_wide (jmp_s2_r[2+g]),
        .i_addr     (I_REQ_D.addr),
        .o_stat     (O_STAT[g]),
        .o_rd_hit   (rd_hit[g]),
        .o_wr_hit   (wr_hit[g]),
        .o_off      (blk_off[g])
      );
    end
  endgenerate

  // ****************************************
  // request decode
  // ****************************************
  // block A wins when both regions overlap
  assign sel      = !(I_REQ_D.wr ? wr_hit[0] : rd_hit[0]);
  assign any_hit  = I_REQ_D.wr ? |wr_hit : |rd_hit;
  assign start    = I_CE && (st_r == ST_IDLE) && I_REQ && any_hit;
  assign wide_sel = O_STAT[sel].wide;
  assign nbytes   = (I_REQ_D.size == SZ_BYTE)  ? `RFBI_N_BYTE
                  : (I_REQ_D.size == SZ_HALF)  ? `RFBI_N_HALF
                  : (I_REQ_D.size == SZ_WORD)  ? `RFBI_N_WORD
                  : (I_REQ_D.size == SZ_DWORD) ? `RFBI_N_DWORD : `RFBI_N_BURST;
  assign size_ok  = wide_sel ? (I_REQ_D.size == SZ_WORD && I_REQ_D.addr[1:0] == 2'h0)
                             : (I_REQ_D.size == SZ_BYTE);
  assign wr_ok    = size_ok && O_STAT[sel].cfg.wen;
  assign skip     = I_REQ_D.wr && !wr_ok;
  assign n_acc    = I_REQ_D.wr ? `RFBI_ONE_ACC
                  : wide_sel ? ((I_REQ_D.size == SZ_BURST) ? `RFBI_BURST_BEATS : `RFBI_ONE_ACC)
                  : nbytes;

  // ****************************************
  // access sequencing
  // ****************************************
  // reads wait for the pin synchroniser before capture
  // programmed access time
  assign limit    = wr_r ? {1'b0, atime_r} : {1'b0, atime_r} + `RFBI_SYNC_LAT;
  assign acc_end  = I_CE && (st_r == ST_ACC) && (cnt_r == limit);
  assign last     = (left_r == `RFBI_ONE_ACC);
  assign beat_end = wide_r || last || (off_r[2:0] == `RFBI_LAST_LANE);
  assign off_step = off_r + (wide_r ? `RFBI_STEP_WIDE : `RFBI_STEP_NARROW);
  assign go       = (start && !skip) || (acc_end && !last);
  assign off_nxt  = start ? blk_off[sel] : off_step;
  assign addr_nxt = (start ? wide_sel : wide_r) ? off_nxt[25:3]
                                                : {off_nxt[23:3], off_nxt[1:0]};
  // upper device sits on the upper half of the bus
  assign byte_in  = off_r[2] ? din_s2_r[7:0] : din_s2_r[`RFBI_UP_LSB +: 8];

  // each byte read lands in its own lane
  generate
    for (g = 0; g < 8; g++) begin : gen_lane
      assign buf_nxt[63-8*g -: 8] = wide_r ? din_s2_r[63-8*g -: 8]
                                  : (off_r[2:0] == g) ? byte_in : buf_r[63-8*g -: 8];
    end
  endgenerate

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      st_r <= ST_IDLE;
    end else if (I_CE) begin
      case (st_r)
        ST_IDLE: begin
          if (start) begin
            st_r <= skip ? ST_DONE : ST_ACC;
          end
        end
        ST_ACC: begin
          if (acc_end && last) begin
            st_r <= ST_DONE;
          end
        end
        ST_DONE: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      off_r   <= '0;
      left_r  <= 6'h00;
      cnt_r   <= 5'h00;
      wr_r    <= 1'b0;
      wide_r  <= 1'b0;
      blk_r   <= 1'b0;
      atime_r <= 4'h0;
      buf_r   <= 64'h0;
    end else if (I_CE) begin
      if (start) begin
        wr_r    <= I_REQ_D.wr;
        wide_r  <= wide_sel;
        blk_r   <= sel;
        atime_r <= O_STAT[sel].cfg.atime;
        left_r  <= n_acc;
      end else if (acc_end) begin
        left_r  <= left_r - 6'h01;
        buf_r   <= buf_nxt;
      end
      if (go) begin
        off_r <= off_nxt;
        cnt_r <= 5'h00;
      end else if (st_r == ST_ACC) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // ****************************************
  // device and bus outputs
  // ****************************************
  // strobes stay asserted between accesses of one request so reads stream
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_ROM_CS   <= 2'h0;
      O_ROM_ADDR <= 23'h0;
      O_ROM_OE   <= 1'b0;
      O_ROM_WE   <= `RFBI_WE_NONE;
      O_ROM_DOUT <= 64'h0;
      O_ROM_DOE  <= 1'b0;
      O_BUSY     <= 1'b0;
      O_ACK      <= 1'b0;
      O_RVALID   <= 1'b0;
      O_RDATA    <= 64'h0;
    end else if (I_CE) begin
      O_ACK    <= (acc_end && last) || (start && skip);
      O_RVALID <= acc_end && !wr_r && beat_end;
      O_BUSY   <= (start && !skip) || (st_r == ST_ACC && !(acc_end && last));
      if (acc_end && !wr_r && beat_end) begin
        O_RDATA <= buf_nxt;
      end
      if (go) begin
        O_ROM_CS   <= (start ? sel : blk_r) ? 2'h2 : 2'h1;
        O_ROM_ADDR <= addr_nxt;
        O_ROM_OE   <= start ? !I_REQ_D.wr : !wr_r;
      end
      if (start && !skip) begin
        // word writes put the word on both 32-bit halves
        O_ROM_DOE  <= I_REQ_D.wr;
        O_ROM_DOUT <= wide_sel ? {I_REQ_D.wdata, I_REQ_D.wdata}
                    : {24'h0, I_REQ_D.wdata[7:0], 24'h0, I_REQ_D.wdata[7:0]};
        // strobe only after the write enable check
        O_ROM_WE   <= !I_REQ_D.wr ? `RFBI_WE_NONE
                    : blk_off[sel][2] ? `RFBI_WE_LOWER : `RFBI_WE_UPPER;
      end else if (acc_end && last) begin
        O_ROM_CS  <= 2'h0;
        O_ROM_OE  <= 1'b0;
        O_ROM_WE  <= `RFBI_WE_NONE;
        O_ROM_DOE <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_we_gated;
    @(posedge I_MCLK) disable iff (I_RST)
    (O_ROM_WE != `RFBI_WE_NONE) |-> O_STAT[blk_r].cfg.wen;
  endproperty
  a_we_gated: assert property (p_we_gated) else $error("strobe with write disabled");

  property p_narrow_wr;
    @(posedge I_MCLK) disable iff (I_RST)
    (start && I_REQ_D.wr && !wide_sel && I_REQ_D.size != SZ_BYTE) |=> O_ACK && O_ROM_WE == 2'h0;
  endproperty
  a_narrow_wr: assert property (p_narrow_wr) else $error("non-byte write not ignored");

  property p_wide_wr;
    @(posedge I_MCLK) disable iff (I_RST)
    (O_ROM_WE != `RFBI_WE_NONE && wide_r) |-> off_r[1:0] == 2'h0;
  endproperty
  a_wide_wr: assert property (p_wide_wr) else $error("unaligned wide write strobed");

  property p_atime;
    @(posedge I_MCLK) disable iff (I_RST)
    $fell(O_ROM_OE) |-> $past(cnt_r) == $past(limit);
  endproperty
  a_atime: assert property (p_atime) else $error("read strobe length wrong");

  property p_map16;
    @(posedge I_MCLK) disable iff (I_RST)
    (O_ROM_CS != 2'h0 && !wide_r) |-> O_ROM_ADDR == {off_r[23:3], off_r[1:0]};
  endproperty
  a_map16: assert property (p_map16) else $error("16-bit address map wrong");

  property p_map64;
    @(posedge I_MCLK) disable iff (I_RST)
    (O_ROM_CS != 2'h0 && wide_r) |-> O_ROM_ADDR == off_r[25:3];
  endproperty
  a_map64: assert property (p_map64) else $error("64-bit address map wrong");

  property p_claim;
    @(posedge I_MCLK) disable iff (I_RST)
    (start && !I_REQ_D.wr) |-> rd_hit[sel];
  endproperty
  a_claim: assert property (p_claim) else $error("read claimed for disabled block");

  property p_burst64;
    @(posedge I_MCLK) disable iff (I_RST)
    (start && !I_REQ_D.wr && wide_sel && I_REQ_D.size == SZ_BURST) |=> left_r == 6'h04;
  endproperty
  a_burst64: assert property (p_burst64) else $error("burst access count wrong");

  property p_byte_reads;
    @(posedge I_MCLK) disable iff (I_RST)
    (start && !I_REQ_D.wr && !wide_sel) |=> left_r == $past(nbytes);
  endproperty
  a_byte_reads: assert property (p_byte_reads) else $error("16-bit read count wrong");
endmodule

// ===== sim/rfbi_rom_model.sv
// behavioural rom/flash pair behind both blocks: upper device on [63:32], lower on [31:0]
module rfbi_rom_model (
  input  wire logic        i_clk,
  input  wire logic [1:0]  i_cs,
  input  wire logic [22:0] i_addr,
  input  wire logic        i_oe,
  output logic [63:0]      o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] last_r;
  logic [63:0] word_nxt;
  logic        drive;
  assign word_nxt = {{9'h000, i_addr} ^ 32'hA5A5A5A5, {9'h000, i_addr} ^ 32'h5A5A5A5A};
  assign drive    = i_oe & (|i_cs);
  // released pins show the inverse of the last driven value, never a stale match
  assign o_din    = drive ? word_nxt : ~last_r;
  initial last_r = 64'h0000000000000000;
  always @(posedge i_clk) begin
    if (drive) begin
      last_r <= word_nxt;
    end
  end
endmodule

// ===== sim/rfbi_top_test.sv
// self-checking bench of the rom/flash block interface
module rfbi_top_test
  import rfbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_MCLK = 1'b0, I_RST = 1'b1, I_CE = 1'b1, I_REQ = 1'b0, O_BUSY, O_ACK, O_RVALID;
  logic [1:0] I_CFG_WE = 2'h0, I_JMP_RVE = 2'h1, I_JMP_WIDE = 2'h1, O_ROM_CS, O_ROM_WE;
  rfbi_cfg_s I_CFG = '0;
  rfbi_req_s I_REQ_D = '0;
  rfbi_stat_s [1:0] O_STAT;
  logic [63:0] I_ROM_DIN, O_RDATA, O_ROM_DOUT, dout_seen;
  logic [22:0] O_ROM_ADDR, addr_seen;
  logic        O_ROM_OE, O_ROM_DOE, got_ack, act_seen, doe_seen;
  logic [1:0]  we_seen, cs_seen;
  logic [63:0] beats[$];
  int          n_edges, busy_n, miscompares = 0, samples_checked = 0;
  rfbi_top rfbi_top_inst (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CE(I_CE), .I_CFG_WE(I_CFG_WE),
    .I_CFG(I_CFG), .I_JMP_RVE(I_JMP_RVE), .I_JMP_WIDE(I_JMP_WIDE), .I_REQ(I_REQ),
    .I_REQ_D(I_REQ_D), .I_ROM_DIN(I_ROM_DIN), .O_STAT(O_STAT), .O_BUSY(O_BUSY), .O_ACK(O_ACK),
    .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .O_ROM_CS(O_ROM_CS), .O_ROM_ADDR(O_ROM_ADDR),
    .O_ROM_OE(O_ROM_OE), .O_ROM_WE(O_ROM_WE), .O_ROM_DOUT(O_ROM_DOUT), .O_ROM_DOE(O_ROM_DOE));
  rfbi_rom_model rfbi_rom_model_inst (.i_clk(I_MCLK), .i_cs(O_ROM_CS), .i_addr(O_ROM_ADDR),
    .i_oe(O_ROM_OE), .o_din(I_ROM_DIN));
  always #2.5 I_MCLK = ~I_MCLK;
  function automatic logic [31:0] up_w(input logic [22:0] a);
    return {9'h000, a} ^ 32'hA5A5A5A5;
  endfunction
  function automatic logic [31:0] lo_w(input logic [22:0] a);
    return {9'h000, a} ^ 32'h5A5A5A5A;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cfg(input logic [1:0] b, input rfbi_cfg_s c);
    @(posedge I_MCLK);
    I_CFG <= c;
    I_CFG_WE <= b;
    @(posedge I_MCLK);
    I_CFG_WE <= 2'h0;
    @(posedge I_MCLK);
  endtask
  // ********************************
  // one request, held until the ack or 60 edges
  // ********************************
  task automatic req(input logic [31:0] a, input logic w, input rfbi_size_e s,
                     input logic [31:0] d);
    rfbi_req_s r;
    r = '{addr: a, wr: w, size: s, wdata: d};
    n_edges = 0;
    got_ack = 1'b0;
    act_seen = 1'b0;
    we_seen = 2'h0;
    busy_n = 0;
    doe_seen = 1'b0;
    beats.delete();
    @(posedge I_MCLK);
    I_REQ <= 1'b1;
    I_REQ_D <= r;
    while (!got_ack && n_edges < 60) begin
      @(posedge I_MCLK);
      n_edges++;
      if (O_ROM_WE !== 2'h0) begin
        we_seen = we_seen | O_ROM_WE;
        dout_seen = O_ROM_DOUT;
        doe_seen = O_ROM_DOE;
      end
      if (O_BUSY === 1'b1) busy_n++;
      if (!act_seen && (O_ROM_OE === 1'b1 || O_ROM_WE !== 2'h0)) begin
        act_seen = 1'b1;
        addr_seen = O_ROM_ADDR;
        cs_seen = O_ROM_CS;
      end
      if (O_RVALID === 1'b1) beats.push_back(O_RDATA);
      if (O_ACK === 1'b1) got_ack = 1'b1;
    end
    I_REQ <= 1'b0;
    @(posedge I_MCLK);
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset();
    chk("base a", 64'hFF0, O_STAT[0].cfg.base);
    chk("base b", 64'hFF4, O_STAT[1].cfg.base);
    chk("size", 64'h0, {O_STAT[0].cfg.size, O_STAT[1].cfg.size});
    chk("en wen a", 64'h0, {O_STAT[0].cfg.en, O_STAT[0].cfg.wen});
    chk("en wen b", 64'h0, {O_STAT[1].cfg.en, O_STAT[1].cfg.wen});
    chk("ready", 64'h3, {O_STAT[1].ready, O_STAT[0].ready});
    chk("rve", 64'h1, {O_STAT[1].cfg.rve, O_STAT[0].cfg.rve});
    chk("wide", 64'h1, {O_STAT[1].wide, O_STAT[0].wide});
    $display("test reset done");
  endtask
  task automatic t_alias();
    req(32'hFF000000, 1'b0, SZ_DWORD, 32'h0);
    chk("disabled ack", 64'h0, got_ack);
    req(32'hFFF00008, 1'b0, SZ_DWORD, 32'h0);
    chk("alias edges", 64'd5, n_edges);
    chk("alias busy", 64'd3, busy_n);
    chk("alias cs", 64'h1, cs_seen);
    chk("alias addr", 64'h1, addr_seen);
    chk("alias data", {up_w(23'h1), lo_w(23'h1)}, beats[0]);
    $display("test alias done");
  endtask
  task automatic t_wide();
    cfg(2'h1, '{en: 1'b1, wen: 1'b1, rve: 1'b1, base: 12'hFF0, size: 3'h0, atime: 4'h2});
    chk("wide kept", 64'h1, O_STAT[0].wide);
    req(32'hFF000010, 1'b0, SZ_DWORD, 32'h0);
    chk("atime edges", 64'd7, n_edges);
    chk("atime busy", 64'd5, busy_n);
    chk("dword data", {up_w(23'h2), lo_w(23'h2)}, beats[0]);
    req(32'hFF000020, 1'b0, SZ_BURST, 32'h0);
    chk("burst beats", 64'd4, beats.size());
    for (int i = 0; i < 4 && i < beats.size(); i++) begin
      chk("burst data", {up_w(23'h4 + i), lo_w(23'h4 + i)}, beats[i]);
    end
    chk("burst edges", 64'd22, n_edges);
    chk("burst busy", 64'd20, busy_n);
    req(32'hFF000004, 1'b1, SZ_WORD, 32'h1234ABCD);
    chk("word we", 64'h1, we_seen);
    chk("word addr", 64'h0, addr_seen);
    chk("word dout", 64'h1234ABCD, dout_seen[31:0]);
    chk("word doe", 64'h1, doe_seen);
    req(32'hFF000002, 1'b1, SZ_WORD, 32'h0);
    chk("misaligned we", 64'h4, {got_ack, we_seen});
    req(32'hFF000008, 1'b1, SZ_BYTE, 32'h0);
    chk("byte we wide", 64'h4, {got_ack, we_seen});
    $display("test wide done");
  endtask
  task automatic t_narrow();
    cfg(2'h2, '{en: 1'b1, wen: 1'b0, rve: 1'b0, base: 12'hFF4, size: 3'h1, atime: 4'h0});
    req(32'hFF400005, 1'b1, SZ_BYTE, 32'h55);
    chk("wen off", 64'h4, {got_ack, we_seen});
    cfg(2'h2, '{en: 1'b1, wen: 1'b1, rve: 1'b0, base: 12'hFF4, size: 3'h1, atime: 4'h0});
    req(32'hFF400005, 1'b1, SZ_BYTE, 32'h55);
    chk("byte we", 64'h1, we_seen);
    chk("byte addr", 64'h1, addr_seen);
    chk("byte cs", 64'h2, cs_seen);
    req(32'hFF40000A, 1'b1, SZ_HALF, 32'h0);
    chk("half ignored", 64'h4, {got_ack, we_seen});
    req(32'hFF40000C, 1'b0, SZ_WORD, 32'h0);
    chk("word edges", 64'd14, n_edges);
    chk("word beats", 64'd1, beats.size());
    chk("word bytes", {32'h0, 8'h5E, 8'h5F, 8'h5C, 8'h5D}, {32'h0, beats[0][31:0]});
    req(32'hFF500000, 1'b0, SZ_BYTE, 32'h0);
    chk("size hit", 64'd5, n_edges);
    chk("size byte", 64'hA5, beats[0][63:56]);
    $display("test narrow done");
  endtask
  initial begin
    repeat (10) @(posedge I_MCLK);
    I_RST <= 1'b0;
    repeat (6) @(posedge I_MCLK);
    t_reset();
    t_alias();
    t_wide();
    t_narrow();
    results();
  end
  initial begin
    #20000;
    miscompares++;
    results();
  end
endmodule
